// ### mos_override.sv
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ns
// Overview of operation
// - remote start fixes mains as its inverse
// - mains indicators follow remote start input
// - per-input contact sense and active level
// - action 3 suppresses alarms from input
// - start inhibit forces mains healthy
// - running engine does normal return and cooldown
// - inhibit, or simulation in delayed mode, shows mains present
// - inhibit or simulation release restores measured mains status
// - remote start overrides inhibit and forced start
// - delayed simulation idle forces mains healthy
// - delayed simulation starts only on real failure
// - running engine holds simulation for on-time
// - remote start wins over delayed simulation
// - alternating relay toggles on on/off periods
// - zero hour period means two minutes
// - priority input selects master or slave
// - each function mapped to any input
module mos_override
  import mos_pkg::*;
#(
  parameter int unsigned NIN        = mos_pkg::NUM_INPUTS,
  parameter int unsigned SEC_CYCLES = mos_pkg::SEC_CYCLES
)(
  // clock and reset
  input  wire logic              CLOCK,
  input  wire logic              RST,
  // register port
  input  wire logic [3:0]        ADDR,
  input  wire logic [31:0]       WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [31:0]       RDATA,
  // contact inputs (raw pin levels) and measured status
  input  wire logic [NIN-1:0]    DIN,
  input  wire logic              MAINS_MEAS_OK,
  input  wire logic              GEN_ON_LOAD,
  input  wire logic              ENGINE_RUNNING,
  input  wire logic              FORCE_START_REQ,
  // decisions
  output logic                   MAINS_OK_EFF,
  output logic                   MAINS_LED,
  output logic                   FORCE_START,
  output logic                   ALT_RELAY,
  output logic                   MASTER,
  output logic                   PRIORITY_MODE,
  output logic      [NIN-1:0]    ALARM_EN
);

  // ----------------------------------------------------------------
  // input sync
  // ----------------------------------------------------------------
  logic [NIN-1:0] din_s1_q;
  logic [NIN-1:0] din_s2_q;
  logic           meas_s1_q;
  logic           meas_s2_q;

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      din_s1_q  <= '0;
      din_s2_q  <= '0;
      meas_s1_q <= 1'b0;
      meas_s2_q <= 1'b0;
    end
    else
    begin
      din_s1_q  <= DIN;
      din_s2_q  <= din_s1_q;
      meas_s1_q <= MAINS_MEAS_OK;
      meas_s2_q <= meas_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [1:0]     ctrl_q;
  logic [NIN-1:0] nc_q;
  logic [NIN-1:0] neg_q;
  logic [15:0]    action_q;
  logic [31:0]    funcsel_q;
  logic [7:0]     alt_on_q;
  logic [7:0]     alt_off_q;

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      ctrl_q    <= '0;
      nc_q      <= '0;
      neg_q     <= '0;
      action_q  <= '0;
      funcsel_q <= FUNCSEL_RST;
      alt_on_q  <= ALT_RST;
      alt_off_q <= ALT_RST;
    end
    else if (WR)
    begin
      case (ADDR)
        REG_CTRL:    ctrl_q    <= WDATA[1:0];
        REG_SENSE:
        begin
          nc_q  <= WDATA[NIN-1:0];
          neg_q <= WDATA[NIN+15:16];
        end
        REG_ACTION:  action_q  <= WDATA[15:0];
        REG_FUNCSEL: funcsel_q <= WDATA;
        REG_ALT_ON:  alt_on_q  <= WDATA[7:0];
        REG_ALT_OFF: alt_off_q <= WDATA[7:0];
        default:     ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // input conditioning
  // ----------------------------------------------------------------
  // a contact switching to battery negative pulls the pin low when closed
  logic [NIN-1:0] active;
  logic [NIN-1:0] alarm_en_d;

  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++)
    begin : g_in
      assign active[gi] = din_s2_q[gi] ^ neg_q[gi] ^ nc_q[gi];
      // alarms only from inputs whose action is not "none"
      assign alarm_en_d[gi] = (action_q[2*gi +: 2] != ACTION_NONE);
    end
  endgenerate

  // selection decode, used for each of the four functions
  function automatic logic fn_defined(input logic [3:0] sel);
    fn_defined = (sel != SEL_NONE) && (int'(sel) < NIN);
  endfunction : fn_defined

  function automatic logic fn_level(input logic [3:0] sel, input logic [NIN-1:0] act);
    fn_level = fn_defined(sel) ? act[sel[2:0]] : 1'b0;
  endfunction : fn_level

  logic [3:0] sel_rs;
  logic [3:0] sel_inh;
  logic [3:0] sel_sim;
  logic [3:0] sel_pri;
  assign sel_rs  = funcsel_q[4*MOS_FN_REMOTE   +: 4];
  assign sel_inh = funcsel_q[4*MOS_FN_INHIBIT  +: 4];
  assign sel_sim = funcsel_q[4*MOS_FN_SIMULATE +: 4];
  assign sel_pri = funcsel_q[4*MOS_FN_PRIORITY +: 4];

  logic rs_def;
  logic rs_act;
  logic inh_act;
  logic sim_def;
  logic sim_act;
  logic pri_def;
  logic pri_act;
  assign rs_def  = fn_defined(sel_rs);
  assign rs_act  = fn_level(sel_rs, active);
  assign inh_act = fn_level(sel_inh, active);
  assign sim_def = fn_defined(sel_sim);
  assign sim_act = fn_level(sel_sim, active);
  assign pri_def = fn_defined(sel_pri);
  assign pri_act = fn_level(sel_pri, active);

  // ----------------------------------------------------------------
  // seconds tick
  // ----------------------------------------------------------------
  logic [SEC_CNT_W-1:0] sec_cnt_q;
  logic                 sec_tick;
  assign sec_tick = (sec_cnt_q == SEC_CNT_W'(SEC_CYCLES - 1));

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      sec_cnt_q <= '0;
    else if (sec_tick)
      sec_cnt_q <= '0;
    else
      sec_cnt_q <= sec_cnt_q + 1'b1;
  end

  // period in seconds, 0 hours stands for the short test period
  function automatic logic [23:0] period_secs(input logic [7:0] hours);
    if (hours == 8'h00)
      period_secs = 24'(ZERO_HOUR_SECS);
    else
      period_secs = 24'(hours * SECS_PER_HOUR);
  endfunction : period_secs

  // ----------------------------------------------------------------
  // alternating relay
  // ----------------------------------------------------------------
  logic [23:0] alt_cnt_q;
  logic        alt_q;
  logic [23:0] alt_limit;
  assign alt_limit = alt_q ? period_secs(alt_on_q) : period_secs(alt_off_q);

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      alt_cnt_q <= '0;
      alt_q     <= 1'b0;
    end
    else if (!ctrl_q[CTRL_ALT_EN])
    begin
      alt_cnt_q <= '0;
      alt_q     <= 1'b0;
    end
    else if (sec_tick)
    begin
      if (alt_cnt_q + 24'h000001 >= alt_limit)
      begin
        alt_cnt_q <= '0;
        alt_q     <= ~alt_q;
      end
      else
        alt_cnt_q <= alt_cnt_q + 24'h000001;
    end
  end

  // ----------------------------------------------------------------
  // delayed mains simulation
  // ----------------------------------------------------------------
  // a running set keeps charging for the on-time before simulation applies
  logic        sim_prev_q;
  logic        hold_q;
  logic [23:0] hold_cnt_q;
  logic        delayed_en;
  assign delayed_en = ctrl_q[CTRL_DELAYED_SIM] && sim_def && !rs_def;
  logic        hold_start;
  assign hold_start = sim_act && !sim_prev_q && ENGINE_RUNNING;

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      sim_prev_q <= 1'b0;
      hold_q     <= 1'b0;
      hold_cnt_q <= '0;
    end
    else
    begin
      sim_prev_q <= sim_act;
      if (!delayed_en || !sim_act)
      begin
        hold_q     <= 1'b0;
        hold_cnt_q <= '0;
      end
      else if (hold_start)
      begin
        hold_q     <= 1'b1;
        hold_cnt_q <= '0;
      end
      else if (hold_q && sec_tick)
      begin
        if (hold_cnt_q + 24'h000001 >= period_secs(alt_on_q))
          hold_q <= 1'b0;
        hold_cnt_q <= hold_cnt_q + 24'h000001;
      end
    end
  end

  // simulation latches once applied so taking the load later does not cancel it
  logic sim_applied_q;
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      sim_applied_q <= 1'b0;
    else if (!delayed_en || !sim_act)
      sim_applied_q <= 1'b0;
    else if (!hold_q && !hold_start && (!GEN_ON_LOAD || ENGINE_RUNNING))
      sim_applied_q <= 1'b1;
  end

  // ----------------------------------------------------------------
  // effective mains decision
  // ----------------------------------------------------------------
  logic mains_ok_d;
  logic led_d;
  logic force_d;

  always_comb
  begin
    mains_ok_d = meas_s2_q;
    led_d      = meas_s2_q;
    force_d    = FORCE_START_REQ;
    if (rs_def)
    begin
      // measured phases ignored; inhibit and forced start have no say
      mains_ok_d = !rs_act;
      led_d      = !rs_act;
      force_d    = 1'b0;
    end
    else if (inh_act)
    begin
      // a running set sees healthy mains and runs its return and cooldown
      mains_ok_d = 1'b1;
      led_d      = 1'b1;
    end
    else if (sim_applied_q)
    begin
      // start only if measured mains fail and the input is released
      mains_ok_d = 1'b1;
      led_d      = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      MAINS_OK_EFF  <= 1'b1;
      MAINS_LED     <= 1'b1;
      FORCE_START   <= 1'b0;
      ALT_RELAY     <= 1'b0;
      MASTER        <= 1'b1;
      PRIORITY_MODE <= 1'b0;
      ALARM_EN      <= '0;
    end
    else
    begin
      MAINS_OK_EFF  <= mains_ok_d;
      MAINS_LED     <= led_d;
      FORCE_START   <= force_d;
      ALT_RELAY     <= alt_q;
      MASTER        <= !pri_def || pri_act;
      PRIORITY_MODE <= pri_def;
      ALARM_EN      <= alarm_en_d;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      RDATA <= '0;
    else if (RD)
    begin
      case (ADDR)
        REG_CTRL:    RDATA <= {30'h0, ctrl_q};
        REG_SENSE:   RDATA <= {8'h0, neg_q, 8'h0, nc_q};
        REG_ACTION:  RDATA <= {16'h0, action_q};
        REG_FUNCSEL: RDATA <= funcsel_q;
        REG_ALT_ON:  RDATA <= {24'h0, alt_on_q};
        REG_ALT_OFF: RDATA <= {24'h0, alt_off_q};
        REG_STATUS:  RDATA <= {24'h0, hold_q, sim_applied_q, pri_act, sim_act,
                               inh_act, rs_act, alt_q, mains_ok_d};
        REG_INPUTS:  RDATA <= {24'h0, active};
        default:     RDATA <= '0;
      endcase
    end
    else
      RDATA <= '0;
  end

endmodule : mos_override

// ### mos_pkg.sv
package mos_pkg;

  // ----------------------------------------------------------------
  // clocking
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned SEC_CYCLES     = CLK_HZ;
  localparam int unsigned SEC_CNT_W      = 25;
  localparam int unsigned ZERO_HOUR_MIN  = 2;
  localparam int unsigned ZERO_HOUR_SECS = ZERO_HOUR_MIN * 60;
  localparam int unsigned SECS_PER_HOUR  = 3600;

  // ----------------------------------------------------------------
  // input configuration
  // ----------------------------------------------------------------
  localparam int unsigned NUM_INPUTS   = 8;
  localparam int unsigned SEL_W        = 4;
  localparam logic [3:0]  SEL_NONE     = 4'hF;
  localparam logic [1:0]  ACTION_NONE  = 2'h3;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_SENSE    = 4'h1;
  localparam logic [3:0] REG_ACTION   = 4'h2;
  localparam logic [3:0] REG_FUNCSEL  = 4'h3;
  localparam logic [3:0] REG_ALT_ON   = 4'h4;
  localparam logic [3:0] REG_ALT_OFF  = 4'h5;
  localparam logic [3:0] REG_STATUS   = 4'h6;
  localparam logic [3:0] REG_INPUTS   = 4'h7;

  localparam int unsigned CTRL_DELAYED_SIM = 0;
  localparam int unsigned CTRL_ALT_EN      = 1;

  localparam logic [31:0] FUNCSEL_RST = 32'h0000_FFFF;
  localparam logic [7:0]  ALT_RST     = 8'h00;

  typedef enum logic [1:0] {
    MOS_FN_REMOTE = 2'h0,
    MOS_FN_INHIBIT,
    MOS_FN_SIMULATE,
    MOS_FN_PRIORITY
  } mos_fn_t;

endpackage : mos_pkg

// ### mos_override_asserts.sv
`timescale 1ns/1ns
module mos_override_asserts
  import mos_pkg::*;
#(
  parameter int unsigned NIN = 8
)(
  // clock, reset and register port
  input logic           CLOCK,
  input logic           RST,
  input logic [3:0]     ADDR,
  input logic [31:0]    WDATA,
  input logic           WR,
  input logic           RD,
  input logic [31:0]    RDATA,
  // status in, decisions out
  input logic           MAINS_MEAS_OK,
  input logic           FORCE_START_REQ,
  input logic           MAINS_OK_EFF,
  input logic           MAINS_LED,
  input logic           FORCE_START,
  input logic           ALT_RELAY,
  input logic           MASTER,
  input logic           PRIORITY_MODE,
  input logic [NIN-1:0] ALARM_EN
);
  logic [15:0] fs_q;
  logic [3:0]  age_q;

  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);

  // ----------------------------------------------------------------
  // shadow of the function map and cycles since it last changed
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      fs_q <= 16'hFFFF;
    else if (WR && ADDR == REG_FUNCSEL)
      fs_q <= WDATA[15:0];
  end

  // checks wait 8 cycles after a remap so the pipeline has drained
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      age_q <= 4'h0;
    else if (WR && ADDR == REG_FUNCSEL)
      age_q <= 4'h0;
    else if (age_q != 4'h8)
      age_q <= age_q + 4'h1;
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_rd_idle; !$past(RD) |-> RDATA == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_master; !PRIORITY_MODE |-> MASTER; endproperty
  a_master: assert property (p_master) else $error("slave without priority input");
  property p_force; FORCE_START |-> $past(FORCE_START_REQ); endproperty
  a_force: assert property (p_force) else $error("forced start without request");
  property p_alt; $changed(ALT_RELAY) |=> $stable(ALT_RELAY)[*8]; endproperty
  a_alt: assert property (p_alt) else $error("relay period too short");
  property p_alarm;
    WR && ADDR == REG_ACTION |-> ##3 ALARM_EN[0] == ($past(WDATA[1:0], 3) != ACTION_NONE);
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm enable wrong");
  property p_meas;
    age_q == 4'h8 && fs_q == 16'hFFFF |-> MAINS_OK_EFF == $past(MAINS_MEAS_OK, 3);
  endproperty
  a_meas: assert property (p_meas) else $error("mains status not followed");
  property p_pmode; age_q == 4'h8 |-> PRIORITY_MODE == (fs_q[15:12] < 4'h8); endproperty
  a_pmode: assert property (p_pmode) else $error("priority mode wrong");
  property p_rs_force; age_q == 4'h8 && fs_q[3:0] < 4'h8 |-> !FORCE_START; endproperty
  a_rs_force: assert property (p_rs_force) else $error("forced start under remote");
  property p_rs_led; age_q == 4'h8 && fs_q[3:0] < 4'h8 |-> MAINS_LED == MAINS_OK_EFF; endproperty
  a_rs_led: assert property (p_rs_led) else $error("indicator off remote input");
endmodule : mos_override_asserts

// ### mos_contacts.sv
`timescale 1ns/1ns
module mos_contacts (
  // logical contact states and wiring options
  input  logic [7:0] act,
  input  logic [7:0] nc,
  input  logic [7:0] neg,
  // pin levels seen by the controller
  output logic [7:0] pin
);
  // a break contact or a negative-rail wiring each invert the pin
  assign pin = act ^ nc ^ neg;
endmodule : mos_contacts

// ### tb_mos_override.sv
`timescale 1ns/1ns
module tb_mos_override;
  import mos_pkg::*;
  localparam int unsigned NIN = 8;
  localparam int unsigned SC  = 20;
  localparam int          P   = SC * ZERO_HOUR_SECS;
  logic        CLOCK, RST, WR, RD, MAINS_MEAS_OK, GEN_ON_LOAD, ENGINE_RUNNING;
  logic        FORCE_START_REQ, MAINS_OK_EFF, MAINS_LED, FORCE_START, ALT_RELAY;
  logic        MASTER, PRIORITY_MODE, held, lat;
  logic [3:0]  ADDR;
  logic [31:0] WDATA, RDATA, ctrl, r;
  logic [7:0]  DIN, ALARM_EN, act, nc, neg;
  logic [15:0] fs, action;
  logic [15:0] cfg [6] = '{16'hFFFF, 16'hFFF3, 16'hFF5F, 16'hF2FF, 16'h7FFF, 16'hF215};
  int          error_cnt, cmp_count, seed, n, i, k;

  mos_override #(.NIN(NIN), .SEC_CYCLES(SC)) DUT (.CLOCK, .RST, .ADDR, .WDATA, .WR, .RD,
    .RDATA, .DIN, .MAINS_MEAS_OK, .GEN_ON_LOAD, .ENGINE_RUNNING, .FORCE_START_REQ,
    .MAINS_OK_EFF, .MAINS_LED, .FORCE_START, .ALT_RELAY, .MASTER, .PRIORITY_MODE, .ALARM_EN);
  mos_contacts u_ext (.act, .nc, .neg, .pin(DIN));

  initial
  begin
    CLOCK = 1'h0;
    forever #25 CLOCK = ~CLOCK;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk

  task wrap_up;
    $display("errors %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  // the gap cycle keeps a strobe from being lowered and raised in one step
  task wr(input logic [3:0] a, input logic [31:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'h1;
    @(posedge CLOCK);
    WR <= 1'h0;
    @(posedge CLOCK);
  endtask : wr

  task rd(input logic [3:0] a, input logic [31:0] e);
    ADDR <= a;
    RD <= 1'h1;
    @(posedge CLOCK);
    RD <= 1'h0;
    @(negedge CLOCK);
    chk(RDATA, e);
    @(posedge CLOCK);
  endtask : rd

  // reference decision, highest precedence first
  function automatic logic m_eff();
    if (fs[3:0] < 4'h8)
      return !act[fs[3:0]];
    if (fs[7:4] < 4'h8 && act[fs[7:4]])
      return 1'h1;
    if (lat)
      return 1'h1;
    return MAINS_MEAS_OK;
  endfunction : m_eff

  // simulation stays applied once set, until the input drops or the mode goes
  task upd_lat;
    lat = ctrl[0] && fs[3:0] > 4'h7 && fs[11:8] < 4'h8 && act[fs[11:8]] && !held
          && (lat || !GEN_ON_LOAD || ENGINE_RUNNING);
  endtask : upd_lat

  task chk_all;
    repeat (6) @(posedge CLOCK);
    @(negedge CLOCK);
    upd_lat();
    chk(MAINS_OK_EFF, m_eff());
    chk(MAINS_LED, m_eff());
    chk(FORCE_START, FORCE_START_REQ && fs[3:0] > 4'h7);
    chk(PRIORITY_MODE, fs[15:12] < 4'h8);
    chk(MASTER, fs[15:12] > 4'h7 || act[fs[15:12]]);
    for (k = 0; k < 8; k++)
      chk(ALARM_EN[k], action[2*k+:2] != ACTION_NONE);
    @(posedge CLOCK);
  endtask : chk_all

  task wait_alt(input logic v);
    n = 0;
    while (ALT_RELAY !== v && n < 3 * P)
    begin
      @(negedge CLOCK);
      n++;
    end
    if (n >= 3 * P)
    begin
      error_cnt++;
      wrap_up();
    end
    chk(n >= P - 2 * SC && n <= P + 2 * SC, 1'h1);
  endtask : wait_alt

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    seed = 86;
    error_cnt = 0;
    cmp_count = 0;
    held = 1'h0;
    lat = 1'h0;
    {RST, WR, RD, ADDR, WDATA, act, nc, neg} = {1'h1, 62'h0};
    {MAINS_MEAS_OK, GEN_ON_LOAD, ENGINE_RUNNING, FORCE_START_REQ} = 4'h8;
    {fs, action, ctrl} = {16'hFFFF, 48'h0};
    repeat (16) @(posedge CLOCK);
    RST <= 1'h0;
    @(posedge CLOCK);
    rd(REG_FUNCSEL, FUNCSEL_RST);
    rd(REG_ALT_ON, {24'h0, ALT_RST});
    wr(4'h9, 32'hFFFF_FFFF);
    rd(4'h9, 32'h0);
    chk_all();
    // random wiring and alarm actions over six fixed function maps
    for (i = 0; i < 24; i++)
    begin
      fs = cfg[i % 6];
      ctrl = 32'(i % 2);
      r = $random(seed);
      nc <= r[7:0];
      neg <= r[15:8];
      action = r[31:16];
      wr(REG_SENSE, {8'h0, r[15:8], 8'h0, r[7:0]});
      rd(REG_SENSE, {8'h0, r[15:8], 8'h0, r[7:0]});
      wr(REG_ACTION, {16'h0, action});
      wr(REG_CTRL, ctrl);
      wr(REG_FUNCSEL, {16'h0, fs});
      rd(REG_FUNCSEL, {16'h0, fs});
      repeat (4)
      begin
        r = $random(seed);
        act <= r[7:0];
        {MAINS_MEAS_OK, GEN_ON_LOAD, FORCE_START_REQ} <= r[10:8];
        chk_all();
        rd(REG_INPUTS, {24'h0, act});
      end
    end
    // simulation raised while the engine runs is held off for the on-time
    fs = 16'hF2FF;
    ctrl = 32'h1;
    act <= 8'h00;
    wr(REG_FUNCSEL, {16'h0, fs});
    wr(REG_CTRL, ctrl);
    {MAINS_MEAS_OK, ENGINE_RUNNING, GEN_ON_LOAD} <= 3'h3;
    chk_all();
    act <= 8'h04;
    held = 1'h1;
    repeat (100) @(negedge CLOCK);
    upd_lat();
    chk(MAINS_OK_EFF, m_eff());
    held = 1'h0;
    repeat (P) @(negedge CLOCK);
    upd_lat();
    chk(MAINS_OK_EFF, m_eff());
    // zero-hour periods fall back to two minutes, off-time first
    wr(REG_CTRL, 32'h2);
    wait_alt(1'h1);
    wait_alt(1'h0);
    wrap_up();
  end
endmodule : tb_mos_override

bind mos_override mos_override_asserts #(.NIN(NIN)) u_chk (.CLOCK, .RST, .ADDR, .WDATA, .WR,
  .RD, .RDATA, .MAINS_MEAS_OK, .FORCE_START_REQ, .MAINS_OK_EFF, .MAINS_LED, .FORCE_START,
  .ALT_RELAY, .MASTER, .PRIORITY_MODE, .ALARM_EN);
